// ==== verilog/dcfc_top.sv ====
// Purpose: Control of one dual-clock FIFO with programmable flag offsets.
// Assumes: Port clocks are pins sampled on clk_i, well below clk_i/4.
//          Each port clock phase lasts at least two clk_i periods.
// Notes:   Write-side and read-side state change only on their own port edge.
//          A port edge reaches the outputs three clk_i edges after the pin.
//          Flags refresh on every rising edge of their own port clock, idle or not.
`timescale 1ns/10ps
module dcfc_top #(
	parameter int DEPTH = dcfc_pkg::DEPTH_DEF
) (
	// System
	input  wire logic                         clk_i,
	input  wire logic                         resetn_i,
	// Write port pins
	input  wire logic                         write_clock_i,
	input  wire logic                         write_enable_first_n_i,
	input  wire logic                         second_enable_or_load_n_i,
	input  wire logic [dcfc_pkg::DATA_W-1:0]  write_data_in_i,
	// Read port pins
	input  wire logic                         read_clock_i,
	input  wire logic                         read_enable_first_n_i,
	input  wire logic                         read_enable_second_n_i,
	input  wire logic                         output_drive_n_i,
	// Data out, three-state as value plus enable
	output logic      [dcfc_pkg::DATA_W-1:0]  read_data_out_o,
	output logic                              read_data_out_oe_o,
	// Status flags, active low
	output logic                              full_flag_n_o,
	output logic                              almost_full_flag_n_o,
	output logic                              empty_flag_n_o,
	output logic                              almost_empty_flag_n_o
);

	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam int SW = dcfc_pkg::DATA_W + 7;

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = g;
		for (int i = PW - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		gray2bin = b;
	endfunction : gray2bin

	function automatic logic [dcfc_pkg::LVL_W-1:0] widen(input logic [PW-1:0] v);
		widen = {{(dcfc_pkg::LVL_W-PW){1'b0}}, v};
	endfunction : widen

	// Words between two pointers; the extra pointer bit tells full from empty
	function automatic logic [PW-1:0] fill_level(
		input logic [PW-1:0] wp,
		input logic [PW-1:0] rp
	);
		fill_level = wp - rp;
	endfunction : fill_level

	// Sixteen-bit threshold from its two offset bytes, one spare bit on top
	function automatic logic [dcfc_pkg::LVL_W-1:0] threshold(
		input logic [dcfc_pkg::OFS_W-1:0] hi,
		input logic [dcfc_pkg::OFS_W-1:0] lo
	);
		threshold = {1'b0, hi, lo};
	endfunction : threshold

	// A pin edge lands in pin_s2_q two clk_i edges after it settles, the edge
	// detector fires in the next cycle and the state moves on the edge after.
	// Sampling every pin through one shared pair of flops keeps data aligned
	// with its clock, at the cost of needing port phases of two clk_i periods.

	// Pin synchronisers: all pins pass two flops together, keeping data aligned
	logic [SW-1:0] pin_s1_q;
	logic [SW-1:0] pin_s2_q;
	logic          wclk_prev_q;
	logic          rclk_prev_q;
	wire  [SW-1:0] pins = {write_clock_i, write_enable_first_n_i, second_enable_or_load_n_i,
		write_data_in_i, read_clock_i, read_enable_first_n_i, read_enable_second_n_i,
		output_drive_n_i};

	wire                         wclk_s  = pin_s2_q[SW-1];
	wire                         wen1_s  = pin_s2_q[SW-2];
	wire                         wen2_s  = pin_s2_q[SW-3];
	wire [dcfc_pkg::DATA_W-1:0]  wdata_s = pin_s2_q[SW-4 -: dcfc_pkg::DATA_W];
	wire                         rclk_s  = pin_s2_q[3];
	wire                         ren1_s  = pin_s2_q[2];
	wire                         ren2_s  = pin_s2_q[1];
	wire                         oe_n_s  = pin_s2_q[0];

	always_ff @(posedge clk_i)
	begin
		pin_s1_q    <= pins;
		pin_s2_q    <= pin_s1_q;
		wclk_prev_q <= wclk_s;
		rclk_prev_q <= rclk_s;
	end

	wire wr_edge = wclk_s & ~wclk_prev_q;
	wire rd_edge = rclk_s & ~rclk_prev_q;

	// State
	dcfc_pkg::dcfc_mode_t        mode_q;
	logic [PW-1:0]               wr_ptr_q;
	logic [PW-1:0]               rd_ptr_q;
	logic [PW-1:0]               wr_gray_q;
	logic [PW-1:0]               rd_gray_q;
	logic [PW-1:0]               wr_gray_s1_q;
	logic [PW-1:0]               wr_gray_s2_q;
	logic [PW-1:0]               rd_gray_s1_q;
	logic [PW-1:0]               rd_gray_s2_q;
	logic [dcfc_pkg::DATA_W-1:0] mem_q [DEPTH];
	logic [dcfc_pkg::OFS_W-1:0]  ofs_q [dcfc_pkg::OFS_NUM];
	logic [1:0]                  ofs_idx_q;
	logic [dcfc_pkg::DATA_W-1:0] read_data_q;
	logic                        oe_q;
	logic                        full_n_q;
	logic                        afull_n_q;
	logic                        empty_n_q;
	logic                        aempty_n_q;

	// Mode decode; the load strobe only exists in flag mode
	wire prog_mode = (mode_q == dcfc_pkg::DCFC_MODE_PROG);
	wire load_act  = prog_mode & ~wen2_s;

	// Write qualification: both modes need the first enable low and the pin high
	wire data_en   = prog_mode ? (~wen1_s & ~load_act)
	                           : (~wen1_s & wen2_s);
	wire wr_fire   = wr_edge & data_en & full_n_q;
	wire ofs_wr    = wr_edge & load_act & ~wen1_s;

	// Read qualification; offset reads bypass the array and the pointers
	wire ren_both  = ~ren1_s & ~ren2_s;
	wire ofs_rd    = rd_edge & load_act & ren_both;
	wire rd_fire   = rd_edge & ren_both & ~load_act & empty_n_q;

	// Pointer crossing: gray codes move one bit per step, so two flops are safe
	wire [PW-1:0] rd_ptr_w = gray2bin(rd_gray_s2_q);
	wire [PW-1:0] wr_ptr_r = gray2bin(wr_gray_s2_q);

	wire [PW-1:0] wr_ptr_d = wr_ptr_q + {{(PW-1){1'b0}}, wr_fire};
	wire [PW-1:0] rd_ptr_d = rd_ptr_q + {{(PW-1){1'b0}}, rd_fire};
	// Each side counts against the other side's pointer as it was two flops ago,
	// so full and empty are pessimistic and never let a word be lost or reread
	wire [PW-1:0] wr_level = fill_level(wr_ptr_d, rd_ptr_w);
	wire [PW-1:0] rd_level = fill_level(wr_ptr_r, rd_ptr_d);

	// Offset registers by name, as the user loads them
	wire [dcfc_pkg::OFS_W-1:0] empty_threshold_low_byte  = ofs_q[dcfc_pkg::IDX_EMPTY_LO];
	wire [dcfc_pkg::OFS_W-1:0] empty_threshold_high_byte = ofs_q[dcfc_pkg::IDX_EMPTY_HI];
	wire [dcfc_pkg::OFS_W-1:0] full_threshold_low_byte   = ofs_q[dcfc_pkg::IDX_FULL_LO];
	wire [dcfc_pkg::OFS_W-1:0] full_threshold_high_byte  = ofs_q[dcfc_pkg::IDX_FULL_HI];

	// A new offset takes effect at the next edge of the side that uses it
	wire [dcfc_pkg::LVL_W-1:0] empty_ofs = threshold(empty_threshold_high_byte,
		empty_threshold_low_byte);
	wire [dcfc_pkg::LVL_W-1:0] full_ofs  = threshold(full_threshold_high_byte,
		full_threshold_low_byte);

	wire full_d   = (wr_level == PW'(DEPTH));
	wire afull_d  = (widen(wr_level) + full_ofs) >= dcfc_pkg::LVL_W'(DEPTH);
	wire empty_d  = (rd_level == '0);
	wire aempty_d = widen(rd_level) <= empty_ofs;

	// Mode is caught by the clocked reset, since reset here is synchronous
	// The strap is seen through the pin flops, so reset must outlast them
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			mode_q <= wen2_s ? dcfc_pkg::DCFC_MODE_DUAL : dcfc_pkg::DCFC_MODE_PROG;
	end

	// Write side. Flags are recomputed on every write edge, not only on writes,
	// so a free-running write clock is what lets full clear after reads
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			wr_ptr_q  <= '0;
			wr_gray_q <= '0;
			full_n_q  <= 1'b1;
			afull_n_q <= 1'b1;
		end
		else if (wr_edge)
		begin
			wr_ptr_q  <= wr_ptr_d;
			wr_gray_q <= bin2gray(wr_ptr_d);
			full_n_q  <= ~full_d;
			afull_n_q <= ~afull_d;
		end
	end

	// Array has no reset; its contents are only meaningful between pointers
	// A full FIFO refuses the write, so no stored word is ever overwritten
	always_ff @(posedge clk_i)
	begin
		if (resetn_i && wr_fire)
			mem_q[wr_ptr_q[AW-1:0]] <= wdata_s;
	end

	// Read side. Flags are recomputed on every read edge, so a free-running
	// read clock is what lets empty clear after writes
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			rd_ptr_q    <= '0;
			rd_gray_q   <= '0;
			read_data_q <= '0;
			empty_n_q   <= 1'b0;
			aempty_n_q  <= 1'b0;
		end
		else if (rd_edge)
		begin
			rd_ptr_q   <= rd_ptr_d;
			rd_gray_q  <= bin2gray(rd_ptr_d);
			empty_n_q  <= ~empty_d;
			aempty_n_q <= ~aempty_d;
			if (rd_fire)
				read_data_q <= mem_q[rd_ptr_q[AW-1:0]];
			else if (ofs_rd)
				read_data_q <= {1'b0, ofs_q[ofs_idx_q]};
		end
	end

	// Gray pointer synchronisers. Both pointers live on clk_i here, yet the
	// crossing is kept so the block stays safe if the port sides are split.

	// Write pointer into the read side
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			wr_gray_s1_q <= '0;
			wr_gray_s2_q <= '0;
		end
		else
		begin
			wr_gray_s1_q <= wr_gray_q;
			wr_gray_s2_q <= wr_gray_s1_q;
		end
	end

	// Read pointer into the write side
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			rd_gray_s1_q <= '0;
			rd_gray_s2_q <= '0;
		end
		else
		begin
			rd_gray_s1_q <= rd_gray_q;
			rd_gray_s2_q <= rd_gray_s1_q;
		end
	end

	// Offset registers; one ring index serves loads and reads alike.
	// A simultaneous load and read is not expected; if it happens the ring
	// still advances only once, and the load wins the write.
	// The index is shared, so a load after reads continues where they stopped.
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			ofs_q[dcfc_pkg::IDX_EMPTY_LO] <= dcfc_pkg::EMPTY_LO_RST;
			ofs_q[dcfc_pkg::IDX_EMPTY_HI] <= dcfc_pkg::EMPTY_HI_RST;
			ofs_q[dcfc_pkg::IDX_FULL_LO]  <= dcfc_pkg::FULL_LO_RST;
			ofs_q[dcfc_pkg::IDX_FULL_HI]  <= dcfc_pkg::FULL_HI_RST;
			ofs_idx_q                     <= dcfc_pkg::IDX_RST;
		end
		else
		begin
			if (ofs_wr)
				ofs_q[ofs_idx_q] <= wdata_s[dcfc_pkg::OFS_W-1:0];
			if (ofs_wr || ofs_rd)
				ofs_idx_q <= ofs_idx_q + 2'h1;
		end
	end

	// Output enable is registered so every output leaves a flop
	// Held off during reset so the bus stays released until the pin is seen
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			oe_q <= 1'b0;
		else
			oe_q <= ~oe_n_s;
	end

	// Outputs straight from their flops; the three-state buffer sits outside
	assign read_data_out_o       = read_data_q;
	assign read_data_out_oe_o    = oe_q;
	assign full_flag_n_o         = full_n_q;
	assign almost_full_flag_n_o  = afull_n_q;
	assign empty_flag_n_o        = empty_n_q;
	assign almost_empty_flag_n_o = aempty_n_q;

endmodule : dcfc_top

// ==== include/dcfc_pkg.sv ====
// Purpose: Constants and types for the dual-clock FIFO control block.
// Assumes: One FIFO of the pair; both port clocks arrive as sampled pins.
// Notes:   Offsets are two-byte thresholds, loaded and read in a ring.
//
// Overview of operation
// - Reset low returns read and write pointers to the first location.
// - After reset full and almost-full read high, empty and almost-empty low.
// - Reset zeroes the output register and restores offset defaults.
// - Writes start on write clock rising edges; full flags change there only.
// - Unrelated or identical write and read clocks both work correctly.
// - Flag mode: first write enable low captures a word each write edge.
// - Written words fill successive locations regardless of concurrent reads.
// - Writes are ignored while full; full clears on a write edge after reads.
// - Reads occur on read clock edges; empty flags change there only.
// - A word moves to the output register only with both read enables low.
// - Reads are ignored while empty; empty clears on a read edge after writes.
// - Output enable low drives data out; high floats the data bus.
// - Second-enable/load level during reset picks dual-enable or flag mode.
// - Dual-enable mode writes when first enable low and second enable high.
// - Four 8-bit offset registers: empty low, empty high, full low, full high.
// - Load low and first enable low write offsets in rotating order.
// - Raising load keeps the ring position; next access takes the next register.
// - Load low and both read enables low read offsets in the same ring.
// - Empty asserts when read pointer equals write pointer, blocking reads.
// - Full asserts after depth writes with no reads.
// - Almost-full at depth minus full offset; almost-empty while count within offset.
// - Both offsets default to 7 words.
package dcfc_pkg;

	localparam int DATA_W    = 9;
	localparam int DEPTH_DEF = 256;
	localparam int OFS_W     = 8;
	localparam int OFS_NUM   = 4;
	localparam int LVL_W     = 17;

	localparam logic [7:0] EMPTY_LO_RST = 8'h07;
	localparam logic [7:0] EMPTY_HI_RST = 8'h00;
	localparam logic [7:0] FULL_LO_RST  = 8'h07;
	localparam logic [7:0] FULL_HI_RST  = 8'h00;

	localparam logic [1:0] IDX_EMPTY_LO = 2'h0;
	localparam logic [1:0] IDX_EMPTY_HI = 2'h1;
	localparam logic [1:0] IDX_FULL_LO  = 2'h2;
	localparam logic [1:0] IDX_FULL_HI  = 2'h3;
	localparam logic [1:0] IDX_RST      = 2'h0;

	typedef enum logic [1:0] {
		DCFC_MODE_DUAL = 2'b01,
		DCFC_MODE_PROG = 2'b10
	} dcfc_mode_t;

endpackage : dcfc_pkg

// ==== tb/dcfc_port_model.sv ====
// Purpose: Port clock of the writing or of the reading agent.
// Assumes: Toggles on clk_i rising edges only.
// Notes:   Free-running through reset, as flags refresh only on port edges.
`timescale 1ns/10ps
module dcfc_port_model #(
	parameter int HALF = 5
) (
	input  wire logic clk_i,
	output logic      port_clock_o
);
	int   cnt_q = 0;
	logic tog_q = 1'b0;
	assign port_clock_o = tog_q;
	// Distinct half periods per agent keep the two domains unrelated
	always_ff @(posedge clk_i)
	begin
		cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
		if (cnt_q == HALF - 1)
			tog_q <= ~tog_q;
	end
endmodule : dcfc_port_model

// ==== tb/dcfc_properties.sv ====
// Purpose: Port-level checks of the dual-clock FIFO control block.
// Assumes: Port pins reach outputs within six clk_i edges.
// Notes:   Edge windows are wide on purpose; latency is checked by the bench.
`timescale 1ns/10ps
module dcfc_properties (
	input wire logic                        clk_i,
	input wire logic                        resetn_i,
	input wire logic                        write_clock_i,
	input wire logic                        read_clock_i,
	input wire logic                        output_drive_n_i,
	input wire logic [dcfc_pkg::DATA_W-1:0] read_data_out_o,
	input wire logic                        read_data_out_oe_o,
	input wire logic                        full_flag_n_o,
	input wire logic                        almost_full_flag_n_o,
	input wire logic                        empty_flag_n_o,
	input wire logic                        almost_empty_flag_n_o
);
	logic [6:0] wsh_q, rsh_q;
	logic [2:0] up_q;
	wire w_recent = |(wsh_q[5:0] & ~wsh_q[6:1]);
	wire r_recent = |(rsh_q[5:0] & ~rsh_q[6:1]);
	always_ff @(posedge clk_i)
	begin
		wsh_q <= {wsh_q[5:0], write_clock_i};
		rsh_q <= {rsh_q[5:0], read_clock_i};
		up_q  <= !resetn_i ? 3'h0 : (up_q == 3'h7 ? up_q : up_q + 3'h1);
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	chk_reset_state: assert property (disable iff (1'b0) !resetn_i |=>
		full_flag_n_o && almost_full_flag_n_o && !empty_flag_n_o && !almost_empty_flag_n_o
		&& read_data_out_o == '0) else $error("reset state wrong");
	chk_full_afull: assert property (!full_flag_n_o |-> !almost_full_flag_n_o)
		else $error("full without almost full");
	chk_empty_aempty: assert property (!empty_flag_n_o |-> !almost_empty_flag_n_o)
		else $error("empty without almost empty");
	chk_full_wr_edge: assert property ($changed(full_flag_n_o) |-> w_recent)
		else $error("full flag moved off write edge");
	chk_afull_wr_edge: assert property ($changed(almost_full_flag_n_o) |-> w_recent)
		else $error("almost full moved off write edge");
	chk_empty_rd_edge: assert property ($changed(empty_flag_n_o) |-> r_recent)
		else $error("empty flag moved off read edge");
	chk_aempty_rd_edge: assert property ($changed(almost_empty_flag_n_o) |-> r_recent)
		else $error("almost empty moved off read edge");
	chk_oe_follow: assert property (up_q == 3'h7 |->
		read_data_out_oe_o == !$past(output_drive_n_i, 3)) else $error("drive enable wrong");
	chk_dout_rd_edge: assert property ($changed(read_data_out_o) |-> r_recent)
		else $error("data out moved off read edge");
	cover property (!full_flag_n_o);
	cover property ($rose(empty_flag_n_o));
	cover property ($fell(read_data_out_oe_o));
endmodule : dcfc_properties
bind dcfc_top dcfc_properties i_props (.clk_i(clk_i), .resetn_i(resetn_i),
	.write_clock_i(write_clock_i), .read_clock_i(read_clock_i),
	.output_drive_n_i(output_drive_n_i), .read_data_out_o(read_data_out_o),
	.read_data_out_oe_o(read_data_out_oe_o), .full_flag_n_o(full_flag_n_o),
	.almost_full_flag_n_o(almost_full_flag_n_o), .empty_flag_n_o(empty_flag_n_o),
	.almost_empty_flag_n_o(almost_empty_flag_n_o));

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the dual-clock FIFO control block.
// Assumes: Enables change one clk after a port clock falls.
// Notes:   Depth shrunk to 16 so full and almost-full are reached quickly.
`timescale 1ns/10ps
module tb_top;
	localparam int DEPTH = 16;
	logic clk = 1'b0, resetn = 1'b0, wen1_n = 1'b1, wen2 = 1'b1, drive_n = 1'b0;
	logic ren1_n = 1'b1, ren2_n = 1'b1, wclk, rclk, e1, e2;
	logic oe, full_n, afull_n, empty_n, aempty_n;
	logic [dcfc_pkg::DATA_W-1:0] din = '0, dout, q;
	logic [dcfc_pkg::DATA_W-1:0] exp_q[$];
	logic [7:0]  ofs[6];
	logic [15:0] rnd = 16'h001D;
	int num_errors = 0, tests_run = 0;
	dcfc_port_model #(.HALF(5)) i_wr_agent (.clk_i(clk), .port_clock_o(wclk));
	dcfc_port_model #(.HALF(6)) i_rd_agent (.clk_i(clk), .port_clock_o(rclk));
	dcfc_top #(.DEPTH(DEPTH)) i_dut (.clk_i(clk), .resetn_i(resetn), .write_clock_i(wclk),
		.write_enable_first_n_i(wen1_n), .second_enable_or_load_n_i(wen2),
		.write_data_in_i(din), .read_clock_i(rclk), .read_enable_first_n_i(ren1_n),
		.read_enable_second_n_i(ren2_n), .output_drive_n_i(drive_n),
		.read_data_out_o(dout), .read_data_out_oe_o(oe), .full_flag_n_o(full_n),
		.almost_full_flag_n_o(afull_n), .empty_flag_n_o(empty_n),
		.almost_empty_flag_n_o(aempty_n));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic afull_n_exp(input int cnt);
		return !(cnt + 7 >= DEPTH);
	endfunction : afull_n_exp
	task automatic chk_data(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_flag(input logic got, input logic exp);
		chk_data({8'h00, got}, {8'h00, exp});
	endtask : chk_flag
	task automatic wr(input logic a, input logic b, input logic [8:0] d);
		@(posedge clk);
		wen1_n <= a;
		wen2   <= b;
		din    <= d;
		@(negedge wclk);
		#1;
	endtask : wr
	task automatic rd(input logic a, input logic b);
		@(posedge clk);
		ren1_n <= a;
		ren2_n <= b;
		@(negedge rclk);
		#1;
	endtask : rd
	task automatic do_reset(input logic mode);
		@(posedge clk);
		resetn <= 1'b0;
		wen2   <= mode;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask : do_reset
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("wrong value at %0t: run hung", $time);
		conclude();
	end
	initial
	begin
		do_reset(1'b1);
		chk_flag(full_n, 1'b1);
		chk_flag(afull_n, 1'b1);
		chk_flag(empty_n, 1'b0);
		chk_flag(aempty_n, 1'b0);
		chk_data(dout, 9'h000);
		chk_flag(oe, 1'b1);
		@(negedge wclk);
		#1;
		// Two skipped writes, a full fill, then one refused write
		for (int i = 0; i < DEPTH + 3; i++)
		begin
			rnd = lfsr(rnd);
			e1 = (i == 3);
			e2 = (i != 5);
			wr(e1, e2, rnd[8:0]);
			if (!e1 && e2 && exp_q.size() < DEPTH)
				exp_q.push_back(rnd[8:0]);
			chk_flag(full_n, exp_q.size() < DEPTH);
			chk_flag(afull_n, afull_n_exp(exp_q.size()));
		end
		wr(1'b1, 1'b1, 9'h000);
		repeat (40) @(posedge clk);
		chk_flag(empty_n, 1'b1);
		chk_flag(aempty_n, 1'b1);
		@(negedge rclk);
		#1;
		rd(1'b0, 1'b1);
		chk_data(dout, 9'h000);
		for (int i = DEPTH; i > 0; i--)
		begin
			rd(1'b0, 1'b0);
			q = exp_q.pop_front();
			chk_data(dout, q);
			chk_flag(aempty_n, i - 1 > 7);
		end
		chk_flag(empty_n, 1'b0);
		rd(1'b0, 1'b0);
		chk_data(dout, q);
		rd(1'b1, 1'b1);
		repeat (40) @(posedge clk);
		chk_flag(full_n, 1'b1);
		@(posedge clk);
		drive_n <= 1'b1;
		repeat (5) @(posedge clk);
		chk_flag(oe, 1'b0);
		drive_n <= 1'b0;
		$display("test dual enable mode done");
		do_reset(1'b0);
		@(negedge rclk);
		#1;
		for (int i = 0; i < 4; i++)
		begin
			rd(1'b0, 1'b0);
			chk_data(dout, (i % 2) ? 9'h000 : 9'h007);
		end
		rd(1'b1, 1'b1);
		@(negedge wclk);
		#1;
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			ofs[i] = rnd[7:0];
			if (i == 5)
			begin
				wr(1'b1, 1'b1, 9'h1FF);
				wr(1'b1, 1'b0, 9'h1FF);
			end
			wr(1'b0, 1'b0, {1'b0, ofs[i]});
		end
		wr(1'b1, 1'b0, 9'h000);
		@(negedge rclk);
		#1;
		for (int i = 0; i < 4; i++)
		begin
			rd(1'b0, 1'b0);
			chk_data(dout, {1'b0, ofs[i + 2]});
		end
		rd(1'b1, 1'b1);
		chk_flag(empty_n, 1'b0);
		chk_flag(full_n, 1'b1);
		$display("test offset ring done");
		conclude();
	end
endmodule : tb_top
